// ==== design/wcpp_pkg.sv ====
// Constants for the wide counter ping-pong control block
package wcpp_pkg;
   localparam logic [7:0] IDX_NARROW_CTL = 8'h00;
   localparam logic [7:0] IDX_SHARED_CTL = 8'h01;
   localparam logic [7:0] IDX_WIDE_CTL = 8'h02;
   localparam logic [7:0] IDX_WIDE_INIT = 8'h04;
   localparam logic [7:0] IDX_NARROW_INIT = 8'h05;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h06;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h07;
   localparam logic [7:0] IDX_PORT_DATA = 8'h08;
   localparam logic [7:0] IDX_CAPTURE = 8'h09;
   localparam int RUN_BIT = 7;
   localparam int ONESHOT_BIT = 6;
   localparam int TIMEOUT_BIT = 5;
   localparam int PRESC_LO = 3;
   localparam int CAP_MASK_BIT = 2;
   localparam int TO_MASK_BIT = 1;
   localparam int PIN_ROUTE_BIT = 0;
   localparam int DEMOD_BIT = 7;
   localparam int COMBO_EN_BIT = 6;
   localparam int COMBO_LO = 4;
   localparam int PP_LO = 2;
   localparam logic [1:0] PP_CODE = 2'h1;
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [15:0] WIDE_INIT_RESET = 16'hFFFF;
   localparam logic [7:0] NARROW_INIT_RESET = 8'hFF;
   localparam int IRQ_WTO = 0;
   localparam int IRQ_CAP = 1;
   localparam int IRQ_NTO = 2;
   localparam logic [2:0] SYNC_RESET = 3'h0;
endpackage

// ==== design/wcpp_top.sv ====
// Wide counter control, ping-pong sequencing and timer pin routing
//Behaviour
//- The wide run bit at position 7 reads the counting state, a write of 1 starts and 0 stops.
//- In transmit mode bit 6 at 0 reloads at terminal count and at 1 halts there.
//- In demodulation mode bit 6 at 0 makes the wide counter act on input edges, at 1 ignore them.
//- The timeout flag at bit 5 sets on every terminal count, write 1 clears, write 0 keeps.
//- Wide bits 4:3 pick the wide count clock as system clock over 1, 2, 4 or 8, kept through stop recovery; the narrow counter counts every clock.
//- Bit 2 gates the capture interrupt and bit 1 gates the timeout interrupt, 1 enabling.
//- Wide control bit 0 at 1 routes the wide counter output to port 3 pin 5, else port data.
//- Narrow control bit 0 set routes the narrow counter output to port 3 pin 4.
//- Shared bit 6 set drives port 3 pin 6 with a combination of both outputs picked by bits 5:4.
//- In ping-pong outside demodulation, a finishing counter with bit 6 set clears its own run bit and the hardware sets the other.
//- Stopping and re-enabling a counter reloads its initial value.
`timescale 1ns/1ps
module wcpp_top
   import wcpp_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic stop_recover,
   input wire logic demod_pin,
   output logic port3_pin4,
   output logic port3_pin5,
   output logic port3_pin6,
   output logic irq
);
   typedef struct packed {
      logic [7:0] wctl;
      logic [7:0] nctl;
      logic [7:0] sctl;
      logic [15:0] wini;
      logic [7:0] nini;
      logic [15:0] wcnt;
      logic [7:0] ncnt;
      logic [15:0] cap;
      logic [2:0] ist;
      logic [2:0] imask;
      logic [7:0] pdat;
      logic [2:0] pre;
      logic [2:0] sync;
      logic filt;
      logic wout;
      logic nout;
      logic p4;
      logic p5;
      logic p6;
      logic irq;
      logic [31:0] rdata;
      logic rdy;
      logic err;
   } wcpp_state_s;
   wcpp_state_s st_r;
   wcpp_state_s st_nxt;
   function automatic logic combo(input logic [1:0] sel, input logic a, input logic b);
      unique case (sel)
         2'h0: combo = a & b;
         2'h1: combo = a | b;
         2'h2: combo = ~(a | b);
         2'h3: combo = ~(a & b);
      endcase
   endfunction
   function automatic logic [7:0] byte_merge(input logic [7:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
      byte_merge = be[0] ? wd[7:0] : old;
   endfunction
   logic [7:0] idx;
   logic mapped;
   logic wr;
   logic tick;
   logic wtc;
   logic ntc;
   logic edge_in;
   logic pp_on;
   logic demod;
   logic [7:0] wv;
   logic [31:0] rsel;
   logic [2:0] pmask;
   always_comb
   begin
      st_nxt = st_r;
      idx = paddr[9:2];
      mapped = (paddr[1:0] == 2'h0) && (paddr[31:10] == 22'h0) &&
               (idx <= IDX_CAPTURE) && (idx != 8'h03);
      wr = psel && penable && st_r.rdy && pwrite && mapped;
      wv = byte_merge(8'h00, pwdata, pstrb);
      demod = st_r.sctl[DEMOD_BIT];
      pp_on = (st_r.sctl[PP_LO+1:PP_LO] == PP_CODE);
      pmask = 3'((4'h1 << st_r.wctl[PRESC_LO+1:PRESC_LO]) - 4'h1);
      tick = ((st_r.pre & pmask) == pmask);
      st_nxt.pre = 3'(st_r.pre + 3'h1);
      // Three-stage input filter
      st_nxt.sync = {st_r.sync[1:0], demod_pin};
      if (st_r.sync[1] == st_r.sync[2])
         st_nxt.filt = st_r.sync[2];
      edge_in = (st_nxt.filt != st_r.filt);
      wtc = 1'b0;
      ntc = 1'b0;
      // Wide counter engine
      if (st_r.wctl[RUN_BIT] && !demod && tick)
      begin
         if (st_r.wcnt == 16'h0)
         begin
            wtc = 1'b1;
            st_nxt.wout = ~st_r.wout;
            st_nxt.wcnt = st_r.wini;
            if (st_r.wctl[ONESHOT_BIT])
               st_nxt.wctl[RUN_BIT] = 1'b0;
         end
         else
            st_nxt.wcnt = 16'(st_r.wcnt - 16'h1);
      end
      if (st_r.wctl[RUN_BIT] && demod)
      begin
         if (edge_in && !st_r.wctl[ONESHOT_BIT])
         begin
            st_nxt.cap = 16'(st_r.wini - st_r.wcnt);
            st_nxt.wcnt = st_r.wini;
            st_nxt.wout = st_nxt.filt;
            if (st_r.wctl[CAP_MASK_BIT])
               st_nxt.ist[IRQ_CAP] = 1'b1;
         end
         else if (tick)
         begin
            if (st_r.wcnt == 16'h0)
            begin
               wtc = 1'b1;
               st_nxt.wcnt = st_r.wini;
            end
            else
               st_nxt.wcnt = 16'(st_r.wcnt - 16'h1);
         end
      end
      // Narrow counter engine
      if (st_r.nctl[RUN_BIT])
      begin
         if (st_r.ncnt == 8'h0)
         begin
            ntc = 1'b1;
            st_nxt.nout = ~st_r.nout;
            st_nxt.ncnt = st_r.nini;
            if (st_r.nctl[ONESHOT_BIT])
               st_nxt.nctl[RUN_BIT] = 1'b0;
         end
         else
            st_nxt.ncnt = 8'(st_r.ncnt - 8'h1);
      end
      if (pp_on && !demod)
      begin
         if (wtc && st_r.wctl[ONESHOT_BIT])
         begin
            st_nxt.nctl[RUN_BIT] = 1'b1;
            st_nxt.ncnt = st_r.nini;
         end
         if (ntc && st_r.nctl[ONESHOT_BIT])
         begin
            st_nxt.wctl[RUN_BIT] = 1'b1;
            st_nxt.wcnt = st_r.wini;
         end
      end
      // Register writes
      if (wr)
      begin
         unique case (idx)
            IDX_WIDE_CTL:
            begin
               if (wv[RUN_BIT] && !st_r.wctl[RUN_BIT])
                  st_nxt.wcnt = st_r.wini;
               st_nxt.wctl[RUN_BIT] = wv[RUN_BIT];
               st_nxt.wctl[ONESHOT_BIT:PRESC_LO] = {wv[ONESHOT_BIT], st_nxt.wctl[TIMEOUT_BIT],
                                                     wv[PRESC_LO+1:PRESC_LO]};
               st_nxt.wctl[CAP_MASK_BIT:PIN_ROUTE_BIT] = wv[CAP_MASK_BIT:PIN_ROUTE_BIT];
               if (wv[TIMEOUT_BIT])
                  st_nxt.wctl[TIMEOUT_BIT] = 1'b0;
            end
            IDX_NARROW_CTL:
            begin
               if (wv[RUN_BIT] && !st_r.nctl[RUN_BIT])
                  st_nxt.ncnt = st_r.nini;
               st_nxt.nctl = {wv[RUN_BIT:ONESHOT_BIT], st_nxt.nctl[TIMEOUT_BIT] & ~wv[TIMEOUT_BIT],
                              wv[4:0]};
            end
            IDX_SHARED_CTL: st_nxt.sctl = wv;
            IDX_WIDE_INIT: st_nxt.wini = pstrb[1] ? {pwdata[15:8], wv} : {st_r.wini[15:8], wv};
            IDX_NARROW_INIT: st_nxt.nini = wv;
            IDX_IRQ_STATUS: st_nxt.ist = (st_r.ist & ~wv[2:0]) | (st_nxt.ist & ~st_r.ist);
            IDX_IRQ_MASK: st_nxt.imask = wv[2:0];
            IDX_PORT_DATA: st_nxt.pdat = wv;
            default: ;
         endcase
      end
      if (wtc)
      begin
         st_nxt.wctl[TIMEOUT_BIT] = 1'b1;
         if (st_r.wctl[TO_MASK_BIT])
            st_nxt.ist[IRQ_WTO] = 1'b1;
      end
      if (ntc)
      begin
         st_nxt.nctl[TIMEOUT_BIT] = 1'b1;
         if (st_r.nctl[TO_MASK_BIT])
            st_nxt.ist[IRQ_NTO] = 1'b1;
      end
      if (stop_recover)
      begin
         st_nxt.wctl = {CTL_RESET[7:5], st_r.wctl[PRESC_LO+1:PRESC_LO], CTL_RESET[2:0]};
         st_nxt.nctl = CTL_RESET;
         st_nxt.sctl = CTL_RESET;
      end
      st_nxt.p5 = st_nxt.wctl[PIN_ROUTE_BIT] ? st_nxt.wout : st_nxt.pdat[5];
      st_nxt.p4 = st_nxt.nctl[PIN_ROUTE_BIT] ? st_nxt.nout : st_nxt.pdat[4];
      st_nxt.p6 = st_nxt.sctl[COMBO_EN_BIT] ?
                  combo(st_nxt.sctl[COMBO_LO+1:COMBO_LO], st_nxt.nout, st_nxt.wout) :
                  st_nxt.pdat[6];
      st_nxt.irq = |(st_nxt.ist & st_nxt.imask);
      // APB read path, no wait states
      unique case (idx)
         IDX_WIDE_CTL: rsel = {24'h0, st_r.wctl};
         IDX_NARROW_CTL: rsel = {24'h0, st_r.nctl};
         IDX_SHARED_CTL: rsel = {24'h0, st_r.sctl};
         IDX_WIDE_INIT: rsel = {16'h0, st_r.wini};
         IDX_NARROW_INIT: rsel = {24'h0, st_r.nini};
         IDX_IRQ_STATUS: rsel = {29'h0, st_r.ist};
         IDX_IRQ_MASK: rsel = {29'h0, st_r.imask};
         IDX_PORT_DATA: rsel = {24'h0, st_r.pdat};
         IDX_CAPTURE: rsel = {16'h0, st_r.cap};
         default: rsel = 32'h0;
      endcase
      st_nxt.rdy = psel && !penable;
      st_nxt.err = psel && !penable && !mapped;
      st_nxt.rdata = (psel && !penable && !pwrite && mapped) ? rsel : 32'h0;
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_r <= '0;
         st_r.wini <= WIDE_INIT_RESET;
         st_r.nini <= NARROW_INIT_RESET;
         st_r.sync <= SYNC_RESET;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end
   assign prdata = st_r.rdata;
   assign pready = st_r.rdy;
   assign pslverr = st_r.err;
   assign port3_pin4 = st_r.p4;
   assign port3_pin5 = st_r.p5;
   assign port3_pin6 = st_r.p6;
   assign irq = st_r.irq;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_run_write;
      wr && idx == IDX_WIDE_CTL && !stop_recover && !(pp_on && ntc) |=> st_r.wctl[RUN_BIT] == $past(wv[RUN_BIT]);
   endproperty
   a_run_write: assert property (p_run_write) else $error("run bit not written");
   property p_oneshot;
      wtc && !demod && st_r.wctl[ONESHOT_BIT] && !(pp_on && ntc) && !wr |=> !st_r.wctl[RUN_BIT];
   endproperty
   a_oneshot: assert property (p_oneshot) else $error("one-shot did not halt");
   property p_modulo;
      wtc && !demod && !st_r.wctl[ONESHOT_BIT] && !wr && !stop_recover |=> st_r.wctl[RUN_BIT] && st_r.wcnt == $past(st_r.wini);
   endproperty
   a_modulo: assert property (p_modulo) else $error("modulo reload missing");
   property p_ignore_edge;
      demod && st_r.wctl[ONESHOT_BIT] |=> $stable(st_r.cap);
   endproperty
   a_ignore_edge: assert property (p_ignore_edge) else $error("edge not ignored");
   property p_timeout_set;
      wtc && !stop_recover |=> st_r.wctl[TIMEOUT_BIT];
   endproperty
   a_timeout_set: assert property (p_timeout_set) else $error("timeout flag lost");
   property p_presc_keep;
      stop_recover |=> st_r.wctl[PRESC_LO+1:PRESC_LO] == $past(st_r.wctl[PRESC_LO+1:PRESC_LO]);
   endproperty
   a_presc_keep: assert property (p_presc_keep) else $error("prescale lost on recovery");
   property p_to_gate;
      wtc && !st_r.wctl[TO_MASK_BIT] && !st_r.ist[IRQ_WTO] |=> !st_r.ist[IRQ_WTO];
   endproperty
   a_to_gate: assert property (p_to_gate) else $error("gated timeout raised");
   property p_pin5;
      st_r.wctl[PIN_ROUTE_BIT] |-> port3_pin5 == st_r.wout;
   endproperty
   a_pin5: assert property (p_pin5) else $error("pin 5 route wrong");
   property p_pin4;
      st_r.nctl[PIN_ROUTE_BIT] |-> port3_pin4 == st_r.nout;
   endproperty
   a_pin4: assert property (p_pin4) else $error("pin 4 route wrong");
   property p_pin6;
      st_r.sctl[COMBO_EN_BIT] |-> port3_pin6 == combo(st_r.sctl[5:4], st_r.nout, st_r.wout);
   endproperty
   a_pin6: assert property (p_pin6) else $error("pin 6 combination wrong");
   property p_pingpong;
      pp_on && !demod && wtc && st_r.wctl[ONESHOT_BIT] && !wr && !stop_recover |=> st_r.nctl[RUN_BIT] && st_r.ncnt == $past(st_r.nini);
   endproperty
   a_pingpong: assert property (p_pingpong) else $error("ping-pong handover missed");
   property p_restart;
      wr && idx == IDX_WIDE_CTL && wv[RUN_BIT] && !st_r.wctl[RUN_BIT] && !stop_recover |=> st_r.wcnt == $past(st_r.wini);
   endproperty
   a_restart: assert property (p_restart) else $error("restart did not reload");
   c_pingpong: cover property (pp_on && wtc ##[1:300] ntc);
   c_capture: cover property (demod && edge_in && st_r.wctl[RUN_BIT]);
   c_irq: cover property ($rose(irq));
endmodule // wcpp_top

// ==== dv/tb_top.sv ====
// Self-checking bench for the wide counter ping-pong control block
`timescale 1ns/1ps
module tb_top
   import wcpp_pkg::*;
;
   typedef struct packed {logic [7:0] idx; logic [31:0] rst; logic [31:0] wd; logic [31:0] exp;} wcpp_row_s;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hF;
   logic stop_recover = 1'b0;
   logic demod_pin = 1'b0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic port3_pin4;
   logic port3_pin5;
   logic port3_pin6;
   logic irq;
   logic [2:0] pins;
   logic [31:0] q;
   logic e;
   int n_mismatch = 0;
   int n_compared = 0;
   int cyc = 0;
   wcpp_row_s rows [9] = '{
      '{IDX_NARROW_CTL, 32'h0, 32'h43, 32'h43},
      '{IDX_SHARED_CTL, 32'h0, 32'h70, 32'h70},
      '{IDX_WIDE_CTL, 32'h0, 32'h5E, 32'h5E},
      '{IDX_WIDE_INIT, 32'hFFFF, 32'h1234, 32'h1234},
      '{IDX_NARROW_INIT, 32'hFF, 32'h5A, 32'h5A},
      '{IDX_IRQ_MASK, 32'h0, 32'h07, 32'h07},
      '{IDX_PORT_DATA, 32'h0, 32'h70, 32'h70},
      '{IDX_CAPTURE, 32'h0, 32'h55, 32'h0},
      '{IDX_IRQ_STATUS, 32'h0, 32'h07, 32'h0}};
   assign pins = {port3_pin6, port3_pin5, port3_pin4};
   always #20 pclk = ~pclk;
   always @(posedge pclk) cyc <= cyc + 1;
   wcpp_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .stop_recover(stop_recover),
      .demod_pin(demod_pin), .port3_pin4(port3_pin4), .port3_pin5(port3_pin5),
      .port3_pin6(port3_pin6), .irq(irq));
   task automatic print_verdict;
      $display("Counts: %0d compared, %0d mismatched", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_compared++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   // One APB transfer, waits for pready
   task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
      int k;
      k = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {22'h0, idx, 2'h0};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 16);
      chk({31'h0, pready}, 32'h1, "pready");
      if (pready !== 1'b1)
         print_verdict();
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      apb(1'b1, idx, d);
   endtask
   task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input string m);
      apb(1'b0, idx, 32'h0);
      chk(q, exp, m);
   endtask
   // Reads until one bit has the wanted value
   task automatic poll(input logic [7:0] idx, input int b, input logic v, input string m);
      int k;
      k = 0;
      do
      begin
         apb(1'b0, idx, 32'h0);
         k++;
      end
      while (q[b] !== v && k < 400);
      chk({31'h0, q[b]}, {31'h0, v}, m);
      if (q[b] !== v)
         print_verdict();
   endtask
   task automatic toggles(input int i, input string m);
      int ones;
      ones = 0;
      repeat (64)
      begin
         @(posedge pclk);
         ones += (pins[i] === 1'b1);
      end
      chk({31'h0, ones > 0 && ones < 64}, 32'h1, m);
   endtask
   initial
   begin
      repeat (100000) @(posedge pclk);
      n_mismatch++;
      $display("[ERR] %0t run limit reached", $time);
      print_verdict();
   end
   initial
   begin
      int t0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (rows[i])
      begin
         rd(rows[i].idx, rows[i].rst, "reset value");
         wr(rows[i].idx, rows[i].wd);
         rd(rows[i].idx, rows[i].exp, "readback");
      end
      wr(IDX_NARROW_CTL, 32'h0);
      wr(IDX_WIDE_CTL, 32'h0);
      wr(IDX_PORT_DATA, 32'h0);
      wr(IDX_IRQ_MASK, 32'h0);
      apb(1'b0, 8'h03, 32'h0);
      chk({31'h0, e}, 32'h1, "unmapped error");
      chk(q, 32'h0, "unmapped data");
      $display("test registers done");
      for (int c = 0; c < 4; c++)
      begin
         wr(IDX_SHARED_CTL, 32'h40 | (c << 4));
         repeat (2) @(posedge pclk);
         chk({31'h0, port3_pin6}, {31'h0, c[1]}, "combo pin");
      end
      wr(IDX_SHARED_CTL, 32'h0);
      wr(IDX_PORT_DATA, 32'h70);
      repeat (2) @(posedge pclk);
      chk({29'h0, pins}, 32'h7, "port data pins");
      wr(IDX_PORT_DATA, 32'h0);
      $display("test pins done");
      wr(IDX_WIDE_INIT, 32'h3);
      wr(IDX_WIDE_CTL, 32'h82);
      poll(IDX_IRQ_STATUS, IRQ_WTO, 1'b1, "timeout status");
      chk({31'h0, irq}, 32'h0, "masked irq");
      wr(IDX_IRQ_MASK, 32'h1);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h1, "unmasked irq");
      rd(IDX_WIDE_CTL, 32'hA2, "running with flag");
      wr(IDX_WIDE_CTL, 32'h02);
      rd(IDX_WIDE_CTL, 32'h22, "write 0 keeps flag");
      wr(IDX_WIDE_CTL, 32'h20);
      rd(IDX_WIDE_CTL, 32'h0, "write 1 clears flag");
      wr(IDX_IRQ_STATUS, 32'h1);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0, "irq cleared");
      $display("test timeout done");
      wr(IDX_WIDE_INIT, 32'h10);
      t0 = cyc;
      wr(IDX_WIDE_CTL, 32'hD8);
      poll(IDX_WIDE_CTL, RUN_BIT, 1'b0, "one-shot halt");
      chk({31'h0, cyc - t0 >= 120 && cyc - t0 <= 150}, 32'h1, "divide by 8");
      rd(IDX_WIDE_CTL, 32'h78, "halted state");
      stop_recover <= 1'b1;
      @(posedge pclk);
      stop_recover <= 1'b0;
      rd(IDX_WIDE_CTL, 32'h18, "prescale kept");
      wr(IDX_WIDE_INIT, 32'h100);
      wr(IDX_WIDE_CTL, 32'hC0);
      repeat (40) @(posedge pclk);
      wr(IDX_WIDE_CTL, 32'h40);
      t0 = cyc;
      wr(IDX_WIDE_CTL, 32'hC0);
      poll(IDX_WIDE_CTL, RUN_BIT, 1'b0, "restart halt");
      chk({31'h0, cyc - t0 >= 250 && cyc - t0 <= 275}, 32'h1, "reload on restart");
      wr(IDX_WIDE_CTL, 32'h20);
      $display("test one-shot done");
      wr(IDX_WIDE_INIT, 32'h3);
      wr(IDX_WIDE_CTL, 32'h81);
      toggles(1, "wide pin");
      wr(IDX_WIDE_CTL, 32'h20);
      wr(IDX_NARROW_INIT, 32'h3);
      wr(IDX_NARROW_CTL, 32'h81);
      toggles(0, "narrow pin");
      wr(IDX_NARROW_CTL, 32'h20);
      repeat (2) @(posedge pclk);
      chk({31'h0, port3_pin5}, 32'h0, "route off");
      $display("test routing done");
      wr(IDX_NARROW_INIT, 32'h40);
      wr(IDX_WIDE_INIT, 32'h40);
      wr(IDX_NARROW_CTL, 32'h40);
      wr(IDX_WIDE_CTL, 32'h40);
      wr(IDX_SHARED_CTL, 32'h04);
      wr(IDX_NARROW_CTL, 32'hC0);
      poll(IDX_WIDE_CTL, RUN_BIT, 1'b1, "wide takes over");
      apb(1'b0, IDX_NARROW_CTL, 32'h0);
      chk({31'h0, q[RUN_BIT]}, 32'h0, "narrow stopped");
      poll(IDX_NARROW_CTL, RUN_BIT, 1'b1, "narrow takes over");
      apb(1'b0, IDX_WIDE_CTL, 32'h0);
      chk({31'h0, q[RUN_BIT]}, 32'h0, "wide stopped");
      wr(IDX_SHARED_CTL, 32'h0);
      wr(IDX_NARROW_CTL, 32'h20);
      wr(IDX_WIDE_CTL, 32'h20);
      $display("test ping-pong done");
      wr(IDX_IRQ_STATUS, 32'h7);
      wr(IDX_SHARED_CTL, 32'h80);
      for (int s = 0; s < 2; s++)
      begin
         wr(IDX_WIDE_CTL, s ? 32'hC4 : 32'h84);
         demod_pin <= 1'b1;
         repeat (8) @(posedge pclk);
         demod_pin <= 1'b0;
         repeat (8) @(posedge pclk);
         apb(1'b0, IDX_IRQ_STATUS, 32'h0);
         chk({31'h0, q[IRQ_CAP]}, {31'h0, s == 0}, "edge capture");
         wr(IDX_WIDE_CTL, 32'h20);
         wr(IDX_IRQ_STATUS, 32'h7);
      end
      wr(IDX_SHARED_CTL, 32'h0);
      $display("test demodulation done");
      print_verdict();
   end
endmodule // tb_top
